// >>> hdl/output_compare_cfg.svh
// Register offsets, field positions, reset values and codes for the output compare channel.
// Assumes inclusion by its bare name from the package and the channel module.
`ifndef OUTPUT_COMPARE_CFG_SVH
`define OUTPUT_COMPARE_CFG_SVH

// Byte addresses of the registers on the APB.
`define OC_ADDR_CONTROL 12'h000
`define OC_ADDR_PRIMARY 12'h004
`define OC_ADDR_SECONDARY 12'h008
`define OC_ADDR_STATUS 12'h00c
`define OC_ADDR_MASK 12'h010
`define OC_ADDR_WIDTH 12

// Control register fields.
`define OC_CTRL_MODE_LSB 0
`define OC_CTRL_MODE_MSB 2
`define OC_CTRL_TSEL_BIT 3
`define OC_CTRL_FAULT_BIT 4
`define OC_CTRL_IDLE_BIT 13
`define OC_CTRL_WMASK 16'h200f

// Mode field codes.
`define OC_MODE_OFF 3'h0
`define OC_MODE_RISE 3'h1
`define OC_MODE_FALL 3'h2
`define OC_MODE_TOGGLE 3'h3
`define OC_MODE_ONE_PULSE 3'h4
`define OC_MODE_CONT_PULSE 3'h5
`define OC_MODE_PWM 3'h6
`define OC_MODE_PWM_FAULT 3'h7

// Interrupt status and mask fields.
`define OC_IRQ_COMPARE_BIT 0
`define OC_IRQ_FAULT_BIT 1
`define OC_IRQ_WIDTH 2

// Reset values.
`define OC_CTRL_RESET 16'h0000
`define OC_CMP_RESET 16'h0000
`define OC_IRQ_RESET 2'h0

`endif

// >>> hdl/output_compare_channel.sv
// One output compare channel with an APB register slave and a level interrupt.
// Assumes two shared 16-bit timers outside, whose values and period pulses arrive
// synchronous to pclk, and a pad that uses the output enable (low = driven).
`timescale 1ns/1ps
`default_nettype none
`include "output_compare_cfg.svh"

module output_compare_channel #(
    parameter int CHANNEL_INDEX = 1
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire output_compare_pkg::apb_req_type apb_req,
    output output_compare_pkg::apb_rsp_type apb_rsp,
    // Shared timers and system state.
    input wire output_compare_pkg::timer_bus_type timers,
    input wire logic cpu_idle,
    // Fault inputs, active on a falling edge.
    input wire logic fault_input_first,
    input wire logic fault_input_second,
    // Output pin and interrupt.
    output logic compare_output_pin,
    output logic compare_output_pin_oe_n,
    output logic irq
);
    import output_compare_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Registers and helpers.

    logic [2:0] mode_r;
    logic timer_select_r;
    logic idle_stop_select_r;
    logic fault_status_flag_r;
    logic [15:0] primary_compare_register_r;
    logic [15:0] secondary_compare_register_r;
    logic [`OC_IRQ_WIDTH-1:0] irq_status_r;
    logic [`OC_IRQ_WIDTH-1:0] irq_mask_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [2:0] mode_prev_r;
    logic primary_match_prev_r;
    logic secondary_match_prev_r;
    logic fault_prev_r;
    logic pin_r;
    pulse_state_type pulse_state_r;

    logic [15:0] timer_value;
    logic period_edge;
    logic running;
    logic mode_entry;
    logic primary_event;
    logic secondary_event;
    logic fault_pin;
    logic fault_event;
    logic compare_irq_event;
    logic [15:0] control_view;
    logic wr_access;
    logic rd_setup;
    logic [`OC_ADDR_WIDTH-1:0] addr;
    logic is_pwm;
    logic halted;
    logic pwm_fault_mode;
    logic ctrl_write;
    logic primary_write;
    logic secondary_write;
    logic status_write;
    logic mask_write;
    logic [`OC_IRQ_WIDTH-1:0] irq_status_nxt;
    logic [31:0] read_nxt;

    // Reset view of the control register, split into its fields.
    localparam logic [15:0] CTRL_RESET = `OC_CTRL_RESET;
    localparam logic [2:0] MODE_RESET = CTRL_RESET[`OC_CTRL_MODE_MSB:`OC_CTRL_MODE_LSB];
    localparam logic TSEL_RESET = CTRL_RESET[`OC_CTRL_TSEL_BIT];
    localparam logic FAULT_RESET = CTRL_RESET[`OC_CTRL_FAULT_BIT];
    localparam logic IDLE_RESET = CTRL_RESET[`OC_CTRL_IDLE_BIT];

    // A match is an event only in its first cycle, so a stopped timer fires once.
    function automatic logic match_rise(input logic [15:0] value, input logic [15:0] cmp,
                                        input logic prev);
        match_rise = (value == cmp) && !prev;
    endfunction : match_rise

    function automatic logic addr_mapped(input logic [`OC_ADDR_WIDTH-1:0] a);
        addr_mapped = (a == `OC_ADDR_CONTROL) || (a == `OC_ADDR_PRIMARY) ||
                      (a == `OC_ADDR_SECONDARY) || (a == `OC_ADDR_STATUS) ||
                      (a == `OC_ADDR_MASK);
    endfunction : addr_mapped

    ////////////////////////////////////////////////////////////////////////////
    // Time base, halting and event detection.

    assign timer_value = timer_select_r ? timers.second_value : timers.first_value;
    assign period_edge = timer_select_r ? timers.second_period : timers.first_period;
    // A halted channel keeps its state but takes no events.
    assign halted = idle_stop_select_r && cpu_idle;
    assign running = (mode_r != `OC_MODE_OFF) && !halted;
    assign mode_entry = (mode_r != mode_prev_r);
    assign is_pwm = (mode_r == `OC_MODE_PWM) || (mode_r == `OC_MODE_PWM_FAULT);
    assign pwm_fault_mode = (mode_r == `OC_MODE_PWM_FAULT);
    assign fault_pin = (CHANNEL_INDEX <= 4) ? fault_input_first : fault_input_second;
    assign primary_event = running && !mode_entry &&
        match_rise(timer_value, primary_compare_register_r, primary_match_prev_r);
    assign secondary_event = running && !mode_entry &&
        match_rise(timer_value, secondary_compare_register_r, secondary_match_prev_r);
    assign fault_event = running && pwm_fault_mode &&
        fault_prev_r && !fault_pin;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_match_prev_r <= 1'b0;
            secondary_match_prev_r <= 1'b0;
            fault_prev_r <= 1'b1;
            mode_prev_r <= `OC_MODE_OFF;
        end else begin
            primary_match_prev_r <= (timer_value == primary_compare_register_r);
            secondary_match_prev_r <= (timer_value == secondary_compare_register_r);
            fault_prev_r <= fault_pin;
            mode_prev_r <= mode_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin sequencing per mode.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_r <= 1'b0;
            pulse_state_r <= PULSE_WAIT_RISE;
        end else if (mode_entry) begin
            pulse_state_r <= PULSE_WAIT_RISE;
            case (mode_r)
                `OC_MODE_RISE: pin_r <= 1'b0;
                `OC_MODE_FALL: pin_r <= 1'b1;
                `OC_MODE_TOGGLE: pin_r <= pin_r;
                `OC_MODE_ONE_PULSE, `OC_MODE_CONT_PULSE: pin_r <= 1'b0;
                `OC_MODE_PWM, `OC_MODE_PWM_FAULT: begin
                    pin_r <= (primary_compare_register_r != 16'h0000);
                end
                default: pin_r <= pin_r;
            endcase
        end else if (running) begin
            case (mode_r)
                `OC_MODE_RISE: begin
                    if (primary_event) begin
                        pin_r <= 1'b1;
                    end
                end
                `OC_MODE_FALL: begin
                    if (primary_event) begin
                        pin_r <= 1'b0;
                    end
                end
                `OC_MODE_TOGGLE: begin
                    if (primary_event) begin
                        pin_r <= !pin_r;
                    end
                end
                `OC_MODE_ONE_PULSE, `OC_MODE_CONT_PULSE: begin
                    case (pulse_state_r)
                        PULSE_WAIT_RISE: begin
                            if (primary_event) begin
                                pin_r <= 1'b1;
                                pulse_state_r <= PULSE_WAIT_FALL;
                            end
                        end
                        PULSE_WAIT_FALL: begin
                            if (secondary_event) begin
                                pin_r <= 1'b0;
                                pulse_state_r <= (mode_r == `OC_MODE_CONT_PULSE) ?
                                    PULSE_WAIT_RISE : PULSE_DONE;
                            end
                        end
                        PULSE_DONE: pin_r <= 1'b0;
                        default: pulse_state_r <= PULSE_WAIT_RISE;
                    endcase
                end
                `OC_MODE_PWM, `OC_MODE_PWM_FAULT: begin
                    if (fault_event || fault_status_flag_r) begin
                        pin_r <= 1'b0;
                    end else if (period_edge) begin
                        pin_r <= (secondary_compare_register_r != 16'h0000);
                    end else if (primary_event) begin
                        pin_r <= 1'b0;
                    end
                end
                default: pin_r <= pin_r;
            endcase
        end
    end

    assign compare_output_pin = pin_r;
    assign compare_output_pin_oe_n = (mode_r == `OC_MODE_OFF);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt events: the edges each mode reports.

    always_comb begin
        compare_irq_event = 1'b0;
        case (mode_r)
            // One-shot modes report only the edge that really moves the pin.
            `OC_MODE_RISE: begin
                compare_irq_event = primary_event && !pin_r;
            end
            `OC_MODE_FALL: begin
                compare_irq_event = primary_event && pin_r;
            end
            `OC_MODE_TOGGLE: begin
                compare_irq_event = primary_event;
            end
            `OC_MODE_ONE_PULSE, `OC_MODE_CONT_PULSE: begin
                compare_irq_event = secondary_event && (pulse_state_r == PULSE_WAIT_FALL);
            end
            `OC_MODE_PWM, `OC_MODE_PWM_FAULT: begin
                compare_irq_event = 1'b0;
            end
            default: compare_irq_event = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave.

    assign addr = apb_req.paddr[`OC_ADDR_WIDTH-1:0];
    assign wr_access = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                       addr_mapped(addr);
    assign rd_setup = apb_req.psel && !apb_req.penable;

    // One write strobe per register.
    assign ctrl_write = wr_access && (addr == `OC_ADDR_CONTROL);
    assign primary_write = wr_access && (addr == `OC_ADDR_PRIMARY);
    assign secondary_write = wr_access && (addr == `OC_ADDR_SECONDARY);
    assign status_write = wr_access && (addr == `OC_ADDR_STATUS);
    assign mask_write = wr_access && (addr == `OC_ADDR_MASK);

    assign control_view = {2'h0, idle_stop_select_r, 8'h00, fault_status_flag_r,
                           timer_select_r, mode_r};

    // Word returned for the address of the current setup cycle.
    always_comb begin
        read_nxt = 32'h0000_0000;
        case (addr)
            `OC_ADDR_CONTROL: read_nxt = {16'h0000, control_view};
            `OC_ADDR_PRIMARY: read_nxt = {16'h0000, primary_compare_register_r};
            `OC_ADDR_SECONDARY: read_nxt = {16'h0000, secondary_compare_register_r};
            `OC_ADDR_STATUS: read_nxt = {30'h0, irq_status_r};
            `OC_ADDR_MASK: read_nxt = {30'h0, irq_mask_r};
            default: read_nxt = 32'h0000_0000;
        endcase
    end

    // Read data and error are sampled in the setup cycle so both come from flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (rd_setup) begin
            pslverr_r <= !addr_mapped(addr);
            prdata_r <= read_nxt;
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = pslverr_r;
    assign apb_rsp.prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Control register.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= MODE_RESET;
            timer_select_r <= TSEL_RESET;
            idle_stop_select_r <= IDLE_RESET;
        end else if (ctrl_write) begin
            // Writes land as given; software keeps the timer stopped around them.
            mode_r <= apb_req.pwdata[`OC_CTRL_MODE_MSB:`OC_CTRL_MODE_LSB];
            timer_select_r <= apb_req.pwdata[`OC_CTRL_TSEL_BIT];
            idle_stop_select_r <= apb_req.pwdata[`OC_CTRL_IDLE_BIT];
        end
    end

    // The flag ignores software; it drops only when the channel leaves the fault mode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_status_flag_r <= FAULT_RESET;
        end else if (fault_event) begin
            fault_status_flag_r <= 1'b1;
        end else if (!pwm_fault_mode) begin
            fault_status_flag_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare registers.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            primary_compare_register_r <= `OC_CMP_RESET;
        end else if (running && is_pwm && period_edge) begin
            primary_compare_register_r <= secondary_compare_register_r;
        end else if (primary_write) begin
            primary_compare_register_r <= apb_req.pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_compare_register_r <= `OC_CMP_RESET;
        end else if (secondary_write) begin
            secondary_compare_register_r <= apb_req.pwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, mask and output; a new event beats a same-cycle clear.

    always_comb begin
        irq_status_nxt = irq_status_r;
        for (int i = 0; i < `OC_IRQ_WIDTH; i++) begin
            if ((i == `OC_IRQ_COMPARE_BIT) && compare_irq_event) begin
                irq_status_nxt[i] = 1'b1;
            end else if ((i == `OC_IRQ_FAULT_BIT) && fault_event) begin
                irq_status_nxt[i] = 1'b1;
            end else if (status_write && apb_req.pwdata[i]) begin
                irq_status_nxt[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_r <= `OC_IRQ_RESET;
        end else begin
            irq_status_r <= irq_status_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= `OC_IRQ_RESET;
        end else if (mask_write) begin
            irq_mask_r <= apb_req.pwdata[`OC_IRQ_WIDTH-1:0];
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);

endmodule : output_compare_channel
`default_nettype wire

// >>> hdl/output_compare_pkg.sv
// Types shared by the output compare channel and its surroundings.
// Assumes the constants header is on the include path.
`include "output_compare_cfg.svh"

package output_compare_pkg;

    typedef struct packed {
        logic [15:0] first_value;
        logic [15:0] second_value;
        logic first_period;
        logic second_period;
    } timer_bus_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_type;

    typedef enum logic [1:0] {
        PULSE_WAIT_RISE,
        PULSE_WAIT_FALL,
        PULSE_DONE
    } pulse_state_type;

endpackage : output_compare_pkg

// >>> test/oc_far_side.sv
// Far side of the compare channel: the pad with its pull-up and the fault pins.
// Assumes the bench commands faults as levels changed at a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module oc_far_side (
    // Commands from the bench.
    input wire logic trip_first,
    input wire logic trip_second,
    // Pin side of the channel.
    input wire logic pin,
    input wire logic pin_oe_n,
    // Fault pins, idle high, and the pad level.
    output logic fault_first,
    output logic fault_second,
    output logic pad
);
    // A pull-up holds the pad high once the channel lets go of it.
    assign pad = pin_oe_n ? 1'b1 : pin;
    assign fault_first = !trip_first;
    assign fault_second = !trip_second;
endmodule : oc_far_side
`default_nettype wire

// >>> test/output_compare_channel_asserts.sv
// Port-level checks of the compare channel, bound to its top module.
// Assumes control writes complete in one access cycle, as pready stays high.
`timescale 1ns/1ps
`default_nettype none
`include "output_compare_cfg.svh"
module output_compare_channel_asserts #(
    parameter int CHANNEL_INDEX = 1
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire output_compare_pkg::apb_req_type apb_req,
    input wire output_compare_pkg::apb_rsp_type apb_rsp,
    // Timers, system state and fault pins.
    input wire output_compare_pkg::timer_bus_type timers,
    input wire logic cpu_idle,
    input wire logic fault_input_first,
    input wire logic fault_input_second,
    // Output pin and interrupt.
    input wire logic compare_output_pin,
    input wire logic compare_output_pin_oe_n,
    input wire logic irq
);
    import output_compare_pkg::*;
    logic [2:0] mode_r;
    logic idle_r;
    logic acc;
    logic flt;
    assign acc = apb_req.psel && apb_req.penable;
    assign flt = (CHANNEL_INDEX <= 4) ? fault_input_first : fault_input_second;
    // Shadow of the mode and idle-stop control fields, taken from completed writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 3'h0;
            idle_r <= 1'b0;
        end else if (acc && apb_req.pwrite && apb_req.paddr[11:0] == `OC_ADDR_CONTROL) begin
            mode_r <= apb_req.pwdata[2:0];
            idle_r <= apb_req.pwdata[13];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_off_released: assert property (mode_r == 3'h0 |-> compare_output_pin_oe_n)
        else $error("pin driven while channel off");
    a_on_driven: assert property (mode_r != 3'h0 |-> !compare_output_pin_oe_n)
        else $error("pin not driven while channel on");
    a_rise_only: assert property (mode_r == 3'h1 && $past(mode_r) == 3'h1
        && $past(mode_r, 2) == 3'h1 |-> !$fell(compare_output_pin))
        else $error("pin fell in rising one-shot");
    a_fall_only: assert property (mode_r == 3'h2 && $past(mode_r) == 3'h2
        && $past(mode_r, 2) == 3'h2 |-> !$rose(compare_output_pin))
        else $error("pin rose in falling one-shot");
    a_pwm_quiet: assert property (mode_r == 3'h6 && $past(mode_r) == 3'h6
        && !$past(acc) |-> !$rose(irq))
        else $error("interrupt in plain pwm");
    a_fault_drop: assert property (mode_r == 3'h7 && $past(mode_r) == 3'h7
        && $fell(flt) |=> !compare_output_pin ##1 !compare_output_pin)
        else $error("pin not low after fault");
    a_idle_hold: assert property (idle_r && cpu_idle && $past(cpu_idle) && mode_r != 3'h0
        && $past(mode_r, 2) == mode_r |-> $stable(compare_output_pin))
        else $error("pin moved while halted in idle");
    a_unmapped_err: assert property (acc && apb_req.paddr[11:0] > `OC_ADDR_MASK
        |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    a_ctrl_reserved: assert property (acc && !apb_req.pwrite
        && apb_req.paddr[11:0] == `OC_ADDR_CONTROL |-> (apb_rsp.prdata & ~32'h201f) == 32'h0)
        else $error("reserved control bits read nonzero");
endmodule : output_compare_channel_asserts
bind output_compare_channel output_compare_channel_asserts #(.CHANNEL_INDEX(CHANNEL_INDEX)) i_chk (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .timers(timers), .cpu_idle(cpu_idle), .fault_input_first(fault_input_first),
    .fault_input_second(fault_input_second), .compare_output_pin(compare_output_pin),
    .compare_output_pin_oe_n(compare_output_pin_oe_n), .irq(irq));
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for one compare channel with APB tasks and two timers.
// Assumes timers are stopped before every control write and restart from zero.
`timescale 1ns/1ps
`default_nettype none
`include "output_compare_cfg.svh"
module testbench;
    import output_compare_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_type rq = '0;
    apb_rsp_type rs;
    timer_bus_type tim;
    logic cpu_idle = 1'b0;
    logic run = 1'b0;
    logic trip_a = 1'b0;
    logic trip_b = 1'b0;
    logic [15:0] c1 = 16'h0;
    logic [15:0] c2 = 16'h0;
    wire logic fa, fb, pin, oe_n, irq, pad;
    int bad_count = 0;
    int compares = 0;
    int rises, falls, highs;
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        c1 <= run ? (c1 == 16'h0063 ? 16'h0 : c1 + 16'h1) : 16'h0;
        c2 <= run ? (c2 == 16'h003b ? 16'h0 : c2 + 16'h1) : 16'h0;
    end
    assign tim = '{c1, c2, run && c1 == 16'h0063, run && c2 == 16'h003b};
    output_compare_channel i_dut (.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs),
        .timers(tim), .cpu_idle(cpu_idle), .fault_input_first(fa), .fault_input_second(fb),
        .compare_output_pin(pin), .compare_output_pin_oe_n(oe_n), .irq(irq));
    oc_far_side i_far (.trip_first(trip_a), .trip_second(trip_b), .pin(pin), .pin_oe_n(oe_n),
        .fault_first(fa), .fault_second(fb), .pad(pad));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        rq <= '{1'b1, 1'b0, w, {20'h0, a}, d};
        @(posedge pclk);
        rq.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rs.pready !== 1'b1);
        q = rs.prdata;
        e = rs.pslverr;
        rq <= '0;
    endtask : xfer
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        xfer(1'b0, a, 32'h0, q, e);
        chk(what, exp, q);
    endtask : rd
    task automatic setup(input logic [31:0] ctl, input logic [31:0] p, input logic [31:0] s);
        // Passing through the off mode makes the final control write a mode entry whenever ctl selects a mode other than off.
        wr(`OC_ADDR_CONTROL, 32'h0);
        wr(`OC_ADDR_PRIMARY, p);
        wr(`OC_ADDR_SECONDARY, s);
        wr(`OC_ADDR_STATUS, 32'h3);
        wr(`OC_ADDR_CONTROL, ctl);
        repeat (2) @(posedge pclk);
    endtask : setup
    task automatic watch(input int n);
        logic last;
        rises = 0;
        falls = 0;
        highs = 0;
        last = pad;
        run <= 1'b1;
        repeat (n) begin
            @(posedge pclk);
            rises += int'(pad & ~last);
            falls += int'(~pad & last);
            highs += int'(pad);
            last = pad;
        end
        run <= 1'b0;
        @(posedge pclk);
    endtask : watch
    task automatic print_verdict();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rd("control reset", `OC_ADDR_CONTROL, 32'h0);
        rd("status reset", `OC_ADDR_STATUS, 32'h0);
        wr(`OC_ADDR_CONTROL, 32'hfffffff8);
        rd("control bits", `OC_ADDR_CONTROL, 32'h2008);
        xfer(1'b0, 12'h020, 32'h0, q, e);
        chk("unmapped error", 32'h1, e);
        wr(`OC_ADDR_MASK, 32'h3);
        chk("pin released", 32'h1, oe_n);
    endtask : t_regs
    task automatic t_edge(input logic [2:0] m, input logic init);
        setup({29'h0, m}, 32'h14, 32'h0);
        chk("initial pin", init, pad);
        watch(150);
        chk("pin edges", 32'h1, rises + falls);
        chk("final pin", !init, pad);
        rd("event status", `OC_ADDR_STATUS, 32'h1);
        wr(`OC_ADDR_MASK, 32'h0);
        @(posedge pclk);
        chk("masked irq", 32'h0, irq);
        wr(`OC_ADDR_MASK, 32'h3);
        @(posedge pclk);
        chk("irq", 32'h1, irq);
        wr(`OC_ADDR_STATUS, 32'h1);
        @(posedge pclk);
        chk("cleared irq", 32'h0, irq);
    endtask : t_edge
    task automatic t_tsel(input logic [31:0] ctl, input int exp);
        setup(ctl, 32'h50, 32'h0);
        watch(150);
        chk("timer select", exp, rises);
    endtask : t_tsel
    task automatic t_toggle(input logic [31:0] ctl, input logic idle, input int n, input int exp);
        logic lvl;
        lvl = pad;
        setup(ctl, 32'ha, 32'h0);
        chk("kept level", lvl, pad);
        cpu_idle <= idle;
        watch(n);
        cpu_idle <= 1'b0;
        chk("toggles", exp, rises + falls);
    endtask : t_toggle
    task automatic t_pulse(input logic [2:0] m, input int np, input int nh);
        setup({29'h0, m}, 32'ha, 32'h28);
        chk("pulse start", 32'h0, pad);
        watch(300);
        chk("pulses", np, rises);
        chk("high cycles", nh, highs);
        rd("pulse status", `OC_ADDR_STATUS, 32'h1);
    endtask : t_pulse
    task automatic t_pwm();
        setup(32'h6, 32'h0, 32'h1e);
        chk("pwm start", 32'h0, pad);
        watch(250);
        chk("pwm high", 32'h3e, highs);
        rd("reloaded primary", `OC_ADDR_PRIMARY, 32'h1e);
        rd("pwm status", `OC_ADDR_STATUS, 32'h0);
        setup(32'h7, 32'h1e, 32'h1e);
        chk("fault pwm start", 32'h1, pad);
        trip_b <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("other fault pin", 32'h1, pad);
        trip_a <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("fault pin", 32'h0, pad);
        rd("fault status", `OC_ADDR_STATUS, 32'h2);
        wr(`OC_ADDR_CONTROL, 32'h7);
        rd("fault flag", `OC_ADDR_CONTROL, 32'h17);
        trip_a <= 1'b0;
        trip_b <= 1'b0;
        setup(32'h0, 32'ha, 32'h0);
        rd("flag cleared", `OC_ADDR_CONTROL, 32'h0);
        watch(150);
        rd("off status", `OC_ADDR_STATUS, 32'h0);
        chk("off pin", 32'h1, oe_n);
    endtask : t_pwm
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_edge(3'h2, 1'b1);
        t_toggle(32'h3, 1'b0, 100, 1);
        t_edge(3'h1, 1'b0);
        t_tsel(32'h9, 0);
        t_tsel(32'h1, 1);
        t_toggle(32'h2003, 1'b1, 180, 0);
        t_toggle(32'h3, 1'b1, 180, 2);
        t_pulse(3'h4, 1, 30);
        t_pulse(3'h5, 3, 90);
        t_pwm();
        print_verdict();
    end
    initial begin
        #(20 * 20000);
        bad_count++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
